// >>> par_rx_pkg.sv
// shared constants and types for the parallel byte receiver
package par_rx_pkg;

  // clock period of mclk
  localparam longint CLK_NS       = 4;
  // handshake times, as specified, in their own units
  localparam longint BUSY_MIN_NS  = 10000;      // least busy-on time, 10.0 us
  localparam longint IMAGE_NS     = 143000;     // typical busy, image/font data
  localparam longint TEXT_NS      = 2000000;    // typical busy, text data
  localparam longint BUSY_MAX_MS  = 10000;      // longest busy-on time, 10 s
  localparam longint ACK_MIN_NS   = 4500;       // least ack width, 4.5 us
  localparam longint ACK_MAX_NS   = 5000;       // longest ack width, 5 us
  localparam longint REL_TYP_NS   = 100;        // ack-off to busy-off, 0.1 us
  localparam longint NS_PER_MS    = 1000000;

  // cycle counts; least times round up, longest times round down
  localparam logic [31:0] BUSY_MIN_CYC = 32'((BUSY_MIN_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [31:0] IMAGE_CYC    = 32'((IMAGE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [31:0] TEXT_CYC     = 32'((TEXT_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [31:0] BUSY_MAX_CYC = 32'((BUSY_MAX_MS * NS_PER_MS) / CLK_NS);
  localparam logic [31:0] ACK_CYC      = 32'((ACK_MIN_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [31:0] ACK_MAX_CYC  = 32'(ACK_MAX_NS / CLK_NS);
  localparam logic [31:0] REL_CYC      = 32'((REL_TYP_NS + CLK_NS - 1) / CLK_NS);

  // widths and reset levels
  localparam int         BYTE_W     = 8;
  localparam int         FIFO_DEPTH = 16;
  localparam logic [31:0] CNT_ZERO  = 32'h0000_0000;
  localparam logic [31:0] CNT_ONE   = 32'h0000_0001;
  localparam logic       PIN_IDLE   = 1'b1;     // idle level of low-true pins
  localparam logic       AUX_LEVEL  = 1'b0;

  // handshake sequencer, gray along idle-busy-ack-release
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_BUSY = 2'h1,
    ST_ACK  = 2'h3,
    ST_REL  = 2'h2
  } rx_state_type;

  // pins driven by the host
  typedef struct packed {
    logic              strobe_n;
    logic              init_n;
    logic [BYTE_W-1:0] data;     // bit 0 is data line 1
  } host_in_type;

  // pins driven toward the host
  typedef struct packed {
    logic busy;
    logic ack_n;
    logic aux_output_low;
  } host_out_type;

endpackage

// >>> parallel_byte_receive_handshake.sv
// parallel byte receiver: handshake sequencer and its byte fifo
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// byte fifo with a registered output stage
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             mclk,
  input  wire logic             resetn,
  input  wire logic             flush,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr_ptr;
    logic [AW-1:0]               rd_ptr;
    logic [AW:0]                 count;
    logic                        ov;
    logic [WIDTH-1:0]            od;
  } fifo_state_type;

  fifo_state_type f_reg;
  fifo_state_type f_next;
  logic           push;
  logic           load;

  // full is honest: the output stage only takes words the array already holds
  assign in_ready  = (f_reg.count != (AW+1)'(DEPTH));
  assign out_valid = f_reg.ov;
  assign out_data  = f_reg.od;
  assign push      = in_valid && in_ready;
  assign load      = (f_reg.count != '0) && (!f_reg.ov || out_ready);

  // pointer and output stage update
  always_comb begin
    f_next = f_reg;
    if (out_ready && f_reg.ov) begin
      f_next.ov = 1'b0;
    end
    if (push) begin
      f_next.mem[f_reg.wr_ptr] = in_data;
      f_next.wr_ptr            = f_reg.wr_ptr + AW'(1);
    end
    if (load) begin
      f_next.ov     = 1'b1;
      f_next.od     = f_reg.mem[f_reg.rd_ptr];
      f_next.rd_ptr = f_reg.rd_ptr + AW'(1);
    end
    f_next.count = f_reg.count + (AW+1)'(push) - (AW+1)'(load);
    if (flush) begin
      f_next.wr_ptr = '0;
      f_next.rd_ptr = '0;
      f_next.count  = '0;
      f_next.ov     = 1'b0;
    end
  end

  // state register
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      f_reg <= '0;
    end else begin
      f_reg <= f_next;
    end
  end

endmodule // byte_fifo

////////////////////////////////////////////////////////////////////////////////
// What this block does
// [R01] aux output held low while powered
// [R02] host strobe low 0.5 to 500 us
// [R03] busy rises within 0.5 us of strobe
// [R04] online busy lasts 10 us to 10 s
// [R05] busy typically 143 us image, 2 ms text
// [R06] busy falls after ack ends, ~0.1 us
// [R07] ack low pulse 4.5 to 5 us
// [R08] host may restart once busy low
// [R09] data line 1 is lsb, line 8 msb
// [R10] ack issued before busy falls; busy drops with no ack when init ends
// [R11] one ack on going online
// [R12] init input fully reinitialises receiver
// [R13] sync strobe, latch byte on falling edge
module parallel_byte_receive_handshake #(
  parameter logic [31:0] HOLD_IMAGE_CYC = par_rx_pkg::IMAGE_CYC,
  parameter logic [31:0] HOLD_TEXT_CYC  = par_rx_pkg::TEXT_CYC,
  parameter logic [31:0] BUSY_LIMIT_CYC = par_rx_pkg::BUSY_MAX_CYC
) (
  input  wire logic                      mclk,
  input  wire logic                      resetn,
  input  wire par_rx_pkg::host_in_type   host_in,
  input  wire logic                      online,
  input  wire logic                      text_mode,
  output par_rx_pkg::host_out_type       host_out,
  output logic                           byte_valid,
  output logic [par_rx_pkg::BYTE_W-1:0]  byte_data,
  input  wire logic                      byte_ready,
  output logic                           overrun
);
  import par_rx_pkg::*;

  typedef struct packed {
    host_in_type       pin_s1;    // first sync stage, read only by pin_s2
    host_in_type       pin_s2;
    logic              strobe_s3; // previous strobe for edge detect
    logic              online_s1;
    logic              online_s2;
    logic              online_s3;
    rx_state_type      state;
    logic [31:0]       cnt;
    logic              pushed;
    logic [BYTE_W-1:0] rx_byte;
    host_out_type      pins;
    logic              overrun;
  } rx_type;

  rx_type      r_reg;
  rx_type      r_next;
  logic        strobe_fall;
  logic        online_rise;
  logic        init_act;
  logic        push;
  logic        fifo_in_ready;
  logic [31:0] hold_cyc;

  // never wait less than the least busy time, whatever the typical figure
  assign hold_cyc = text_mode ? HOLD_TEXT_CYC : HOLD_IMAGE_CYC;

  // edge detection works only on the second stage and beyond
  assign strobe_fall = r_reg.strobe_s3 && !r_reg.pin_s2.strobe_n;
  assign online_rise = r_reg.online_s2 && !r_reg.online_s3;
  assign init_act    = !r_reg.pin_s2.init_n;
  assign push        = (r_reg.state == ST_BUSY) && !r_reg.pushed;

  // output ports straight from the state flops
  assign host_out = r_reg.pins;
  assign overrun  = r_reg.overrun;

  // sequencer next state
  always_comb begin
    r_next           = r_reg;
    r_next.pin_s1    = host_in;
    r_next.pin_s2    = r_reg.pin_s1;
    r_next.strobe_s3 = r_reg.pin_s2.strobe_n;
    r_next.online_s1 = online;
    r_next.online_s2 = r_reg.online_s1;
    r_next.online_s3 = r_reg.online_s2;
    // [R01] aux pin constant
    r_next.pins.aux_output_low = AUX_LEVEL;
    if (push && fifo_in_ready) begin
      r_next.pushed = 1'b1;
    end
    case (r_reg.state)
      ST_IDLE: begin
        r_next.cnt = CNT_ZERO;
        if (online_rise) begin
          // [R11] ack on going online
          r_next.pins.ack_n = 1'b0;
          r_next.pins.busy  = 1'b1;
          r_next.state      = ST_ACK;
        end else if (!r_reg.online_s2) begin
          r_next.pins.busy = 1'b1;     // offline: refuse bytes
        end else if (strobe_fall) begin
          // [R13] latch byte on edge
          // [R09] line 1 lands in bit 0
          r_next.rx_byte   = r_reg.pin_s2.data;
          r_next.pushed    = 1'b0;
          // [R03] busy one cycle later
          r_next.pins.busy = 1'b1;
          r_next.state     = ST_BUSY;
        end
      end
      ST_BUSY: begin
        r_next.cnt = r_reg.cnt + CNT_ONE;
        // [R04] hold at least minimum
        // [R05] typical hold per mode
        if (r_reg.cnt + CNT_ONE >= BUSY_MIN_CYC && r_reg.cnt + CNT_ONE >= hold_cyc
            && (r_reg.pushed || (push && fifo_in_ready))) begin
          r_next.cnt        = CNT_ZERO;
          // [R10] ack before busy falls
          r_next.pins.ack_n = 1'b0;
          r_next.state      = ST_ACK;
        end else if (r_reg.cnt + CNT_ONE >= BUSY_LIMIT_CYC) begin
          // [R04] give up once busy reaches the 10 s limit, byte dropped
          r_next.cnt        = CNT_ZERO;
          r_next.overrun    = r_reg.overrun || !r_reg.pushed;
          r_next.pushed     = 1'b1;
          r_next.pins.ack_n = 1'b0;
          r_next.state      = ST_ACK;
        end
      end
      ST_ACK: begin
        r_next.cnt = r_reg.cnt + CNT_ONE;
        // [R07] ack width in range
        if (r_reg.cnt + CNT_ONE >= ACK_CYC) begin
          r_next.cnt        = CNT_ZERO;
          r_next.pins.ack_n = PIN_IDLE;
          r_next.state      = ST_REL;
        end
      end
      ST_REL: begin
        r_next.cnt = r_reg.cnt + CNT_ONE;
        // [R06] busy after ack ends
        if (r_reg.cnt + CNT_ONE >= REL_CYC) begin
          r_next.cnt       = CNT_ZERO;
          r_next.pins.busy = !r_reg.online_s2;
          r_next.state     = ST_IDLE;
        end
      end
      default: begin
        r_next.state = ST_IDLE;
      end
    endcase
    // [R12] init reinitialises all but the sync stages and the latched byte
    if (init_act) begin
      r_next.state      = ST_IDLE;
      r_next.cnt        = CNT_ZERO;
      r_next.pushed     = 1'b1;
      r_next.overrun    = 1'b0;
      r_next.pins.ack_n = PIN_IDLE;
      r_next.pins.busy  = 1'b1;   // busy through init; released once init ends while online
    end else if (r_reg.state == ST_IDLE && r_reg.online_s2 && !online_rise
                 && !strobe_fall && r_reg.pins.ack_n) begin
      r_next.pins.busy = r_next.pins.busy && (r_next.state != ST_IDLE);
    end
  end

  // state register, synchronous reset
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      r_reg <= '{pin_s1: '{PIN_IDLE, PIN_IDLE, '0}, pin_s2: '{PIN_IDLE, PIN_IDLE, '0},
                 strobe_s3: PIN_IDLE, online_s1: 1'b0, online_s2: 1'b0,
                 online_s3: 1'b0, state: ST_IDLE, cnt: CNT_ZERO, pushed: 1'b1,
                 rx_byte: '0, pins: '{1'b1, PIN_IDLE, AUX_LEVEL}, overrun: 1'b0};
    end else begin
      r_reg <= r_next;
    end
  end

  // received bytes wait here; a full fifo stretches busy
  byte_fifo #(
    .WIDTH (BYTE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .resetn    (resetn),
    .flush     (init_act),
    .in_valid  (push),
    .in_data   (r_reg.rx_byte),
    .in_ready  (fifo_in_ready),
    .out_valid (byte_valid),
    .out_data  (byte_data),
    .out_ready (byte_ready)
  );

  //////////////////////////////////////////////////////////////////////////////
  // checks
  localparam int C_REL_GAP = int'(REL_CYC) - 1; // busy samples after the first
  logic [31:0] busy_run;
  logic [31:0] ack_run;
  logic        accepting;

  assign accepting = (r_reg.state == ST_IDLE) && r_reg.online_s2 && !online_rise
                     && !init_act && strobe_fall;

  // cycle counters seen only by assertions
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      busy_run <= CNT_ZERO;
      ack_run  <= CNT_ZERO;
    end else begin
      busy_run <= (r_reg.state == ST_BUSY) ? busy_run + CNT_ONE : CNT_ZERO;
      ack_run  <= !host_out.ack_n ? ack_run + CNT_ONE : CNT_ZERO;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  property p_aux_low;
    !host_out.aux_output_low;
  endproperty
  a_aux_low: assert property (p_aux_low) else $error("aux output not low"); // [R01]

  property p_busy_rise;
    accepting |=> host_out.busy && r_reg.state == ST_BUSY;
  endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("busy late"); // [R03]

  property p_busy_min;
    (r_reg.state == ST_BUSY) && (r_next.state == ST_ACK) && !init_act
      |-> busy_run + CNT_ONE >= BUSY_MIN_CYC;
  endproperty
  a_busy_min: assert property (p_busy_min) else $error("busy too short"); // [R04]

  property p_ack_width;
    $rose(host_out.ack_n) && !$past(init_act) |-> ack_run == ACK_CYC;
  endproperty
  a_ack_width: assert property (p_ack_width) else $error("ack width wrong"); // [R07]

  property p_rel_after_ack;
    $rose(host_out.ack_n) && host_out.busy && r_reg.online_s2 && !init_act
      |-> host_out.busy [*1] ##C_REL_GAP host_out.busy ##1 (!host_out.busy || init_act);
  endproperty
  a_rel_after_ack: assert property (p_rel_after_ack) else $error("busy release"); // [R06]

  property p_ack_first;
    // busy also drops when init ends, which sends no ack
    $fell(host_out.busy) && !$past(init_act, 2)
      |-> $past(host_out.ack_n) && $past(r_reg.state) == ST_REL;
  endproperty
  a_ack_first: assert property (p_ack_first) else $error("busy fell no ack"); // [R10]

  property p_online_ack;
    online_rise && !init_act |=> !host_out.ack_n && host_out.busy;
  endproperty
  a_online_ack: assert property (p_online_ack) else $error("no online ack"); // [R11]

  property p_init;
    init_act |=> r_reg.state == ST_IDLE && host_out.ack_n && !r_reg.overrun;
  endproperty
  a_init: assert property (p_init) else $error("init ignored"); // [R12]

  property p_latch;
    accepting |=> r_reg.rx_byte == $past(r_reg.pin_s2.data);
  endproperty
  a_latch: assert property (p_latch) else $error("byte not latched"); // [R13]

  c_byte:   cover property (accepting ##1 host_out.busy [*8] ##[1:1000] !host_out.ack_n);
  c_online: cover property (online_rise ##1 !host_out.ack_n);
  c_init:   cover property (init_act && r_reg.state == ST_BUSY);
  c_full:   cover property (!fifo_in_ready && r_reg.state == ST_BUSY);

endmodule // parallel_byte_receive_handshake

// >>> host_port_model.sv
// host side model: drives strobe, data and init, and times the answers
`timescale 1ns/100ps

module host_port_model (
  input  wire par_rx_pkg::host_out_type host_out,
  input  wire logic                     mclk,
  output par_rx_pkg::host_in_type       host_in
);
  import par_rx_pkg::*;

  // strobe and init idle high until used; data lines start low
  initial host_in = '{strobe_n: PIN_IDLE, init_n: PIN_IDLE, data: 8'h00};

  ////////////////////////////////////////////////////////////////////////////
  // count cycles while busy (sel 0) or ack_n (sel 1) stays at lvl
  task automatic wait_cnt(input bit sel, input logic lvl, output int n);
    n = 0;
    while ((sel ? host_out.ack_n : host_out.busy) === lvl) begin
      @(posedge mclk);
      #1;
      n++;
    end
  endtask

  task automatic set_init(input logic lvl);
    @(posedge mclk);
    #1 host_in.init_n = lvl;
  endtask

  // strobe held w cycles, data line 1 in bit 0
  task automatic strobe_only(input logic [7:0] d, input int w);
    @(posedge mclk);
    #1 host_in.data = d;
    repeat (3) @(posedge mclk);
    #1 host_in.strobe_n = 1'b0;
    repeat (w) @(posedge mclk);
    #1 host_in.strobe_n = 1'b1;
    repeat (3) @(posedge mclk);
    // hold time over: lines no longer show the byte
    #1 host_in.data = ~d;
  endtask

  // starts once busy is low, sync slack only
  task automatic send_byte(input logic [7:0] d, input int w,
                           output int rise, output int hold, output int ackw, output int rel);
    int n;
    wait_cnt(1'b0, 1'b1, n);
    fork
      strobe_only(d, w);
      begin
        // time busy from the strobe's fall, not from the start of the call
        wait (host_in.strobe_n === 1'b0);
        wait_cnt(1'b0, 1'b0, rise);
        wait_cnt(1'b1, 1'b1, hold);
        wait_cnt(1'b1, 1'b0, ackw);
        wait_cnt(1'b0, 1'b1, rel);
      end
    join
  endtask

  // wait for a lone ack pulse, then time it and the busy release
  task automatic watch_ack(output int ackw, output int rel);
    int n;
    wait_cnt(1'b1, 1'b1, n);
    wait_cnt(1'b1, 1'b0, ackw);
    wait_cnt(1'b0, 1'b1, rel);
  endtask
endmodule // host_port_model

// >>> parallel_byte_receive_handshake_tb.sv
// self-checking bench for the parallel byte receiver
`timescale 1ns/100ps

module parallel_byte_receive_handshake_tb;
  import par_rx_pkg::*;

  // short holds keep the run small; hold floor is still 2500 cycles
  localparam logic [31:0] HOLD_IMG = 32'h0000_0064;
  localparam logic [31:0] HOLD_TXT = 32'h0000_0BB8;
  localparam logic [31:0] LIMIT    = 32'h0000_1388;
  localparam int          MAX_CYC  = 98000;

  logic         mclk;
  logic         resetn;
  host_in_type  host_in;
  host_out_type host_out;
  logic         online;
  logic         text_mode;
  logic         byte_valid;
  logic [7:0]   byte_data;
  logic         byte_ready;
  logic         overrun;
  int           n_mismatch;
  int           checks;
  int           cycles;
  logic [7:0]   got[$];

  parallel_byte_receive_handshake #(
    .HOLD_IMAGE_CYC(HOLD_IMG), .HOLD_TEXT_CYC(HOLD_TXT), .BUSY_LIMIT_CYC(LIMIT)
  ) i_parallel_byte_receive_handshake (
    .mclk(mclk), .resetn(resetn), .host_in(host_in), .online(online),
    .text_mode(text_mode), .host_out(host_out), .byte_valid(byte_valid),
    .byte_data(byte_data), .byte_ready(byte_ready), .overrun(overrun)
  );

  host_port_model i_host_port_model (.host_out(host_out), .mclk(mclk), .host_in(host_in));

  ////////////////////////////////////////////////////////////////////////////
  // clock, consumer capture and hang guard
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    if (byte_valid === 1'b1 && byte_ready === 1'b1) got.push_back(byte_data);
    cycles++;
    if (cycles == MAX_CYC) begin
      n_mismatch++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare tasks and verdict
  task automatic check_bit(input string what, input logic exp, input logic seen);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %b, seen %b", what, exp, seen);
    end
  endtask

  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] seen);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic check_range(input string what, input longint lo, input longint hi, input int n);
    checks++;
    if (n < lo || n > hi) begin
      n_mismatch++;
      $display("unexpected %s: expected %0d..%0d, seen %0d", what, lo, hi, n);
    end
  endtask

  task automatic test_done();
    if (n_mismatch == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  function automatic longint hold_floor(input logic [31:0] h);
    return (h > BUSY_MIN_CYC) ? h : BUSY_MIN_CYC;
  endfunction

  // one timed transfer with all handshake figures judged
  task automatic xfer(input logic [7:0] d, input int w, input longint lo);
    int rise, hold, ackw, rel;
    i_host_port_model.send_byte(d, w, rise, hold, ackw, rel);
    check_range("strobe to busy", 0, 4, rise);
    check_range("busy before ack", lo, lo + 4, hold);
    check_range("ack width", ACK_CYC, ACK_MAX_CYC, ackw);
    check_range("ack end to busy off", REL_CYC, REL_CYC, rel);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_online_ack();
    int aw, rl;
    i_host_port_model.watch_ack(aw, rl);
    check_range("online ack width", ACK_CYC, ACK_MAX_CYC, aw);
    check_range("online release", REL_CYC, REL_CYC, rl);
    check_bit("aux level", AUX_LEVEL, host_out.aux_output_low);
  endtask

  task automatic t_bytes();
    got.delete();
    xfer(8'h01, 125, hold_floor(HOLD_IMG));
    xfer(8'h80, 500, hold_floor(HOLD_IMG));
    text_mode = 1'b1;
    xfer(8'hA5, 125, hold_floor(HOLD_TXT));
    text_mode = 1'b0;
    check_range("bytes received", 3, 3, got.size());
    check_byte("lsb line", 8'h01, got[0]);
    check_byte("msb line", 8'h80, got[1]);
    check_byte("text byte", 8'hA5, got[2]);
  endtask

  task automatic t_fill_drain();
    int r, h, a, l;
    byte_ready = 1'b0;
    got.delete();
    for (int i = 0; i < 17; i++) xfer(8'h10 + 8'(i), 125, hold_floor(HOLD_IMG));
    i_host_port_model.send_byte(8'hEE, 125, r, h, a, l);
    check_range("stretched busy", LIMIT - 4, LIMIT + 4, h);
    check_bit("overrun", 1'b1, overrun);
    repeat (60) begin
      @(posedge mclk);
      #1 byte_ready = ~byte_ready;
    end
    check_range("drained count", 17, 17, got.size());
    for (int i = 0; i < 17; i++) check_byte("drained byte", 8'h10 + 8'(i), got[i]);
    check_bit("fifo empty", 1'b0, byte_valid);
  endtask

  task automatic t_init();
    byte_ready = 1'b0;
    xfer(8'h5A, 125, hold_floor(HOLD_IMG));
    // a second byte is still in its busy hold when init arrives
    i_host_port_model.strobe_only(8'hC3, 125);
    i_host_port_model.set_init(1'b0);
    repeat (6) @(posedge mclk);
    #1;
    check_bit("busy in init", 1'b1, host_out.busy);
    check_bit("fifo flushed", 1'b0, byte_valid);
    check_bit("overrun cleared", 1'b0, overrun);
    i_host_port_model.set_init(1'b1);
    repeat (6) @(posedge mclk);
    #1;
    check_bit("busy after init", 1'b0, host_out.busy);
    check_bit("no ack after init", 1'b1, host_out.ack_n);
  endtask

  task automatic t_offline();
    int aw, rl;
    online = 1'b0;
    repeat (8) @(posedge mclk);
    i_host_port_model.strobe_only(8'h3C, 125);
    online = 1'b1;
    i_host_port_model.watch_ack(aw, rl);
    check_range("online again ack", ACK_CYC, ACK_MAX_CYC, aw);
    check_bit("offline strobe ignored", 1'b0, byte_valid);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    n_mismatch = 0;
    checks = 0;
    cycles = 0;
    resetn = 1'b0;
    online = 1'b1;
    text_mode = 1'b0;
    byte_ready = 1'b1;
    repeat (8) @(posedge mclk);
    #1 resetn = 1'b1;
    t_online_ack();
    t_bytes();
    t_fill_drain();
    t_init();
    t_offline();
    test_done();
  end
endmodule // parallel_byte_receive_handshake_tb
